// file: common/coil_drive_pkg.sv
// constants, register map and state layout of the direct coil-drive block
// assumes one 125 MHz clock and synchronous pins
package coil_drive_pkg;
    localparam int unsigned CLK_HZ = 125000000;
    localparam int unsigned BAUD_HZ = 115200;
    localparam int unsigned BIT_CYC = CLK_HZ / BAUD_HZ;
    localparam logic [10:0] BIT_CNT = 11'(BIT_CYC - 1);
    localparam logic [10:0] HALF_CNT = 11'(BIT_CYC / 2);
    localparam logic [6:0] A_GLOBAL_CONFIGURATION = 7'h00;
    localparam logic [6:0] A_CURRENT = 7'h10;
    localparam logic [6:0] A_POWERDOWN = 7'h11;
    localparam logic [6:0] A_POSITION = 7'h21;
    localparam logic [6:0] A_TARGET = 7'h2d;
    localparam logic [6:0] A_CHOPPER = 7'h6c;
    localparam logic [6:0] A_PWMCONF = 7'h70;
    localparam int B_EN_PWM = 2;
    localparam int B_DIRECT = 16;
    localparam int B_AUTOSCALE = 18;
    localparam int B_FW_LO = 20;
    localparam int B_RUNNING_CURRENT_SCALE_LO = 8;
    localparam int B_DELAY_LO = 16;
    localparam int B_COIL_B_LO = 16;
    localparam logic [7:0] SYNC_BYTE = 8'h05;
    localparam logic [7:0] HOST_ADDR = 8'hff;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [5:0] SPI_BITS = 6'h28;
    localparam logic [8:0] DUTY_MIN = 9'h100;
    localparam logic [8:0] DUTY_NEG_FULL = 9'h101;
    localparam logic [1:0] FW_FREE = 2'h1;
    localparam logic [7:0] SCALE_FULL = 8'hff;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_e;

    typedef struct packed {
        logic [8:0] duty;
        logic [7:0] limit;
        logic reg_en;
    } coil_drive_s;

    typedef struct packed {
        logic direct; logic en_pwm; logic autoscale; logic [1:0] fw;
        logic [4:0] standstill_current_scale; logic [4:0] running_current_scale; logic [3:0] hold_dly;
        logic [7:0] pdown; logic [3:0] chopper_off_time; logic [7:0] ampl; logic [7:0] grad;
        logic [31:0] target; logic [31:0] position;
        logic [4:0] cs; logic boost; logic [7:0] pd_cnt; logic [3:0] dly_cnt;
        logic [17:0] pre; logic step_q; logic [7:0] scale;
        logic sclk_q; logic csn_q; logic [39:0] sh; logic [5:0] nbits;
        logic [6:0] rd_addr; logic sdo;
        rx_e rx; logic [10:0] rcnt; logic [2:0] rbit; logic [7:0] rbyte;
        logic [2:0] fidx; logic [7:0] fnode; logic [7:0] freg; logic [31:0] fdata;
        logic [7:0] crc;
        logic [3:0] tbytes; logic [3:0] tbit; logic [10:0] tcnt; logic [9:0] tsh;
        logic [63:0] tbuf; logic tx_o; logic tx_oe;
        coil_drive_s ca; coil_drive_s cb; logic free_o; logic en_o;
    } st_s;
endpackage

// file: verilog/direct_coil_drive.sv
// direct coil-drive block: register file, serial and single-wire access, coil setpoints
// assumes synchronous pins, external bridge stage consumes coil_a/coil_b
// Function
// R1: direct flag set: coil polarity and setting come from target register 0x2d.
// R2: coil A uses bits 8..0, coil B bits 24..16.
// R3: coil current limit is scaled by the standstill current scale.
// R4: direct mode ignores step/direction for positioning; no ramp motion.
// R5: host keeps coil settings within +-248 under the hysteresis chopper.
// R6: host sets voltage mode, autoscale off, amplitude 255, gradient 4, hold 31.
// R7: coil field is signed -255..+255 mapped linearly to full coil voltage.
// R8: autoscale off in voltage mode: current sensing unused.
// R9: hold zero and standstill option 01 lets the coils standstill_output_option.
// R10: autoscale on: limit is hold scale times the coil's absolute duty.
// R11: regulate the larger coil only; its overcurrent scales both duties down.
// R12: hysteresis chopper regulates each bridge independently.
// R13: run current starts on a step pulse, both coils, drops after power-down.
// R14: host pulses step whenever a solenoid coil is switched on.
// R15: serial read: query datagram first, value returned on next access.
// R16: single-wire frame accepted only with a matching checksum byte.
// R17: single-wire node address is 1 while the increment pin is high.
// R18: serial datagram is 40 bits, address byte with write bit, data MSB first.
// R19: write frame 8 bytes, read request 4 bytes, answered with 8 bytes.
`timescale 1ns/1ns
`default_nettype none
module direct_coil_drive #(
    parameter int unsigned PD_TICK = 262144
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic step_in,
    input wire logic [1:0] coil_over_limit,
    input wire logic address_increment_input,
    input wire logic spi_csn,
    input wire logic spi_sclk,
    input wire logic spi_sdi,
    output logic spi_sdo,
    input wire logic uart_in,
    output logic uart_out,
    output logic uart_oe,
    output coil_drive_pkg::coil_drive_s coil_a,
    output coil_drive_pkg::coil_drive_s coil_b,
    output logic coil_standstill_output_option,
    output logic driver_enable
);
    coil_drive_pkg::st_s s, n;

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
        begin
            if (r[7] ^ b[i])
                r = {r[6:0], 1'b0} ^ coil_drive_pkg::CRC_POLY;
            else
                r = {r[6:0], 1'b0};
        end
        return r;
    endfunction

    function automatic logic [31:0] rd(input logic [6:0] a, input coil_drive_pkg::st_s t);
        logic [31:0] v;
        v = 32'h0;
        case (a)
            coil_drive_pkg::A_GLOBAL_CONFIGURATION:
            begin
                v[coil_drive_pkg::B_EN_PWM] = t.en_pwm;
                v[coil_drive_pkg::B_DIRECT] = t.direct;
            end
            coil_drive_pkg::A_CURRENT: v = {12'h0, t.hold_dly, 3'h0, t.running_current_scale, 3'h0, t.standstill_current_scale};
            coil_drive_pkg::A_POWERDOWN: v = {24'h0, t.pdown};
            coil_drive_pkg::A_POSITION: v = t.position;
            coil_drive_pkg::A_TARGET: v = t.target;
            coil_drive_pkg::A_CHOPPER: v = {28'h0, t.chopper_off_time};
            coil_drive_pkg::A_PWMCONF: v = {10'h0, t.fw, 1'b0, t.autoscale, 2'h0, t.grad, t.ampl};
            default: v = 32'h0;
        endcase
        return v;
    endfunction

    function automatic logic [7:0] mag(input logic [8:0] f);
        logic [8:0] m;
        m = f[8] ? 9'(-f) : f;
        return (f == coil_drive_pkg::DUTY_MIN) ? 8'hff : m[7:0];
    endfunction

    logic wen;
    logic [6:0] wa;
    logic [31:0] wd;
    logic [7:0] ma, mb, b;
    logic [7:0] my_node;
    logic tick, step_rise, over;
    logic [8:0] fa, fb;
    logic [16:0] pa, pb;
    logic [12:0] la, lb;
    logic [63:0] rep;
    logic [7:0] rc;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        n = s;
        wen = 1'b0;
        wa = 7'h0;
        wd = 32'h0;
        b = s.rbyte;
        rep = 64'h0;
        rc = 8'h0;
        my_node = {7'h0, address_increment_input}; // R17
        // serial link, mode 3: sample on rising, shift out on falling
        n.sclk_q = spi_sclk;
        n.csn_q = spi_csn;
        if (!spi_csn && s.csn_q)
        begin
            n.sh = {7'h0, s.direct, rd(s.rd_addr, s)}; // R15
            n.nbits = 6'h0;
            n.sdo = 1'b0;
        end
        else if (!spi_csn && spi_sclk && !s.sclk_q)
        begin
            n.sh = {s.sh[38:0], spi_sdi}; // R18
            n.nbits = s.nbits + 6'h1;
        end
        else if (!spi_csn && !spi_sclk && s.sclk_q)
            n.sdo = s.sh[39];
        if (spi_csn && !s.csn_q && s.nbits == coil_drive_pkg::SPI_BITS)
        begin
            if (s.sh[39])
            begin
                wen = 1'b1; // R18
                wa = s.sh[38:32];
                wd = s.sh[31:0];
            end
            else
                n.rd_addr = s.sh[38:32]; // R15
        end
        // single-wire receiver; a timed-out start glitch goes back to idle
        n.rcnt = (s.rcnt == 11'h0) ? 11'h0 : s.rcnt - 11'h1;
        case (s.rx)
            coil_drive_pkg::RX_IDLE:
                if (!uart_in && !s.tx_oe)
                begin
                    n.rx = coil_drive_pkg::RX_START;
                    n.rcnt = coil_drive_pkg::HALF_CNT;
                end
            coil_drive_pkg::RX_START:
                if (s.rcnt == 11'h0)
                begin
                    n.rx = uart_in ? coil_drive_pkg::RX_IDLE : coil_drive_pkg::RX_DATA;
                    n.rcnt = coil_drive_pkg::BIT_CNT;
                    n.rbit = 3'h0;
                end
            coil_drive_pkg::RX_DATA:
                if (s.rcnt == 11'h0)
                begin
                    n.rbyte = {uart_in, s.rbyte[7:1]};
                    n.rbit = s.rbit + 3'h1;
                    n.rcnt = coil_drive_pkg::BIT_CNT;
                    if (s.rbit == 3'h7)
                        n.rx = coil_drive_pkg::RX_STOP;
                end
            coil_drive_pkg::RX_STOP:
                if (s.rcnt == 11'h0)
                begin
                    n.rx = coil_drive_pkg::RX_IDLE;
                    n.crc = crc8(s.crc, b);
                    n.fidx = s.fidx + 3'h1;
                    case (s.fidx)
                        3'h0:
                        begin
                            n.crc = crc8(8'h0, b);
                            if (b != coil_drive_pkg::SYNC_BYTE)
                                n.fidx = 3'h0;
                        end
                        3'h1: n.fnode = b;
                        3'h2: n.freg = b;
                        default: n.fdata = {s.fdata[23:0], b};
                    endcase
                    if ((s.fidx == 3'h3 && !s.freg[7]) || s.fidx == 3'h7)
                    begin
                        n.fidx = 3'h0;
                        n.fdata = s.fdata;
                        if (b == s.crc && s.fnode == my_node) // R16 R17
                        begin
                            if (s.freg[7])
                            begin
                                // serial write wins a same-cycle clash
                                if (!wen)
                                begin
                                    wen = 1'b1;
                                    wa = s.freg[6:0];
                                    wd = s.fdata;
                                end
                            end
                            else
                            begin
                                rep = {coil_drive_pkg::SYNC_BYTE, coil_drive_pkg::HOST_ADDR,
                                       1'b0, s.freg[6:0], rd(s.freg[6:0], s), 8'h0};
                                for (int i = 7; i > 0; i--)
                                    rc = crc8(rc, rep[i*8 +: 8]);
                                n.tbuf = {rep[63:8], rc}; // R19
                                n.tbytes = 4'h8;
                                n.tbit = 4'h0;
                                n.tcnt = coil_drive_pkg::BIT_CNT;
                                n.tsh = {1'b1, rep[63:56], 1'b0};
                            end
                        end
                    end
                end
            default: n.rx = coil_drive_pkg::RX_IDLE;
        endcase
        // single-wire answer: 8 bytes, start/stop framed, LSB first
        if (s.tbytes != 4'h0)
        begin
            n.tcnt = s.tcnt - 11'h1;
            if (s.tcnt == 11'h0)
            begin
                n.tcnt = coil_drive_pkg::BIT_CNT;
                n.tsh = {1'b1, s.tsh[9:1]};
                n.tbit = s.tbit + 4'h1;
                if (s.tbit == 4'h9)
                begin
                    n.tbit = 4'h0;
                    n.tbytes = s.tbytes - 4'h1;
                    n.tbuf = {s.tbuf[55:0], 8'h0};
                    n.tsh = {1'b1, s.tbuf[55:48], 1'b0};
                end
            end
        end
        n.tx_oe = (n.tbytes != 4'h0);
        n.tx_o = n.tx_oe ? n.tsh[0] : 1'b1;
        if (wen)
            case (wa)
                coil_drive_pkg::A_GLOBAL_CONFIGURATION:
                begin
                    n.en_pwm = wd[coil_drive_pkg::B_EN_PWM];
                    n.direct = wd[coil_drive_pkg::B_DIRECT];
                end
                coil_drive_pkg::A_CURRENT:
                begin
                    n.standstill_current_scale = wd[4:0];
                    n.running_current_scale = wd[coil_drive_pkg::B_RUNNING_CURRENT_SCALE_LO +: 5];
                    n.hold_dly = wd[coil_drive_pkg::B_DELAY_LO +: 4];
                end
                coil_drive_pkg::A_POWERDOWN: n.pdown = wd[7:0];
                coil_drive_pkg::A_TARGET: n.target = wd;
                coil_drive_pkg::A_CHOPPER: n.chopper_off_time = wd[3:0];
                coil_drive_pkg::A_PWMCONF:
                begin
                    n.ampl = wd[7:0];
                    n.grad = wd[15:8];
                    n.autoscale = wd[coil_drive_pkg::B_AUTOSCALE];
                    n.fw = wd[coil_drive_pkg::B_FW_LO +: 2];
                end
                default: n.target = n.target;
            endcase
        ////////////////////////////////////////////////////////////////////
        // run/hold current scaling; step only triggers the boost
        n.step_q = step_in;
        step_rise = step_in && !s.step_q && s.direct; // R4
        tick = (s.pre == 18'(PD_TICK - 1));
        n.pre = tick ? 18'h0 : s.pre + 18'h1;
        if (step_rise)
        begin
            n.boost = 1'b1; // R13
            n.cs = s.running_current_scale;
            n.pd_cnt = s.pdown;
            n.pre = 18'h0;
        end
        else if (s.boost)
        begin
            if (tick)
            begin
                n.pd_cnt = s.pd_cnt - 8'h1;
                if (s.pd_cnt == 8'h0)
                begin
                    n.boost = 1'b0;
                    n.dly_cnt = s.hold_dly;
                end
            end
        end
        else if (s.cs > s.standstill_current_scale && s.hold_dly != 4'h0)
        begin
            // gradual drop to hold limits the back-EMF kick on release
            if (tick)
            begin
                n.dly_cnt = (s.dly_cnt == 4'h0) ? s.hold_dly : s.dly_cnt - 4'h1;
                n.cs = (s.dly_cnt == 4'h0) ? s.cs - 5'h1 : s.cs;
            end
        end
        else
            n.cs = s.standstill_current_scale;
        ////////////////////////////////////////////////////////////////////
        fa = s.target[8:0]; // R1 R2
        fb = s.target[coil_drive_pkg::B_COIL_B_LO +: 9]; // R2
        ma = mag(fa); // R7
        mb = mag(fb);
        over = (ma >= mb) ? coil_over_limit[0] : coil_over_limit[1]; // R11
        if (s.en_pwm && s.autoscale)
        begin
            if (over && s.scale != 8'h0)
                n.scale = s.scale - 8'h1; // R11
            else if (!over && s.scale != coil_drive_pkg::SCALE_FULL)
                n.scale = s.scale + 8'h1;
        end
        else
            n.scale = coil_drive_pkg::SCALE_FULL; // R8
        pa = 17'(ma) * 17'({1'b0, s.scale} + 9'h1);
        pb = 17'(mb) * 17'({1'b0, s.scale} + 9'h1);
        la = 13'(ma) * 13'({1'b0, s.cs} + 6'h1); // R3 R10
        lb = 13'(mb) * 13'({1'b0, s.cs} + 6'h1);
        n.ca.limit = s.direct ? la[12:5] : 8'h0;
        n.cb.limit = s.direct ? lb[12:5] : 8'h0;
        // full-negative code is clamped only when raw; scaled duty must still follow scale
        n.ca.duty = !s.direct ? 9'h0 : !s.en_pwm ?
                    ((fa == coil_drive_pkg::DUTY_MIN) ? coil_drive_pkg::DUTY_NEG_FULL : fa) :
                    fa[8] ? 9'(-{1'b0, pa[15:8]}) : {1'b0, pa[15:8]}; // R7 R11
        n.cb.duty = !s.direct ? 9'h0 : !s.en_pwm ?
                    ((fb == coil_drive_pkg::DUTY_MIN) ? coil_drive_pkg::DUTY_NEG_FULL : fb) :
                    fb[8] ? 9'(-{1'b0, pb[15:8]}) : {1'b0, pb[15:8]};
        n.ca.reg_en = s.direct && (!s.en_pwm || (s.autoscale && ma >= mb)); // R12 R11
        n.cb.reg_en = s.direct && (!s.en_pwm || (s.autoscale && mb > ma)); // R12 R11
        n.free_o = s.direct && s.standstill_current_scale == 5'h0 && s.fw == coil_drive_pkg::FW_FREE
                   && !s.boost; // R9
        n.en_o = (s.chopper_off_time != 4'h0);
    end

    always_ff @(posedge ref_clk)
        if (!rst_n)
        begin
            s <= '0;
            s.sclk_q <= 1'b1;
            s.csn_q <= 1'b1;
            s.tx_o <= 1'b1;
            s.scale <= coil_drive_pkg::SCALE_FULL;
        end
        else
            s <= n;

    assign spi_sdo = s.sdo;
    assign uart_out = s.tx_o;
    assign uart_oe = s.tx_oe;
    assign coil_a = s.ca;
    assign coil_b = s.cb;
    assign coil_standstill_output_option = s.free_o;
    assign driver_enable = s.en_o;

    ////////////////////////////////////////////////////////////////////////
    property p_boost_on_step;
        @(posedge ref_clk) disable iff (!rst_n)
        (step_in && !s.step_q && s.direct) |=> (s.boost && s.cs == $past(s.running_current_scale));
    endproperty
    a_boost_on_step: assert property (p_boost_on_step) else $error("no boost on step"); // R13
    property p_no_boost_outside;
        @(posedge ref_clk) disable iff (!rst_n)
        (!s.direct && !s.boost) |=> !s.boost;
    endproperty
    a_no_boost_outside: assert property (p_no_boost_outside) else $error("step used"); // R4
    property p_coil_a_field;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.direct && !s.en_pwm && s.target[8:0] != 9'h100) |=> coil_a.duty == $past(s.target[8:0]);
    endproperty
    a_coil_a_field: assert property (p_coil_a_field) else $error("coil a field"); // R1
    property p_coil_b_field;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.direct && !s.en_pwm && s.target[24:16] != 9'h100) |=> coil_b.duty == $past(s.target[24:16]);
    endproperty
    a_coil_b_field: assert property (p_coil_b_field) else $error("coil b field"); // R2
    property p_single_reg;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.direct && s.en_pwm) |=> !(coil_a.reg_en && coil_b.reg_en);
    endproperty
    a_single_reg: assert property (p_single_reg) else $error("both coils regulated"); // R11
    property p_both_reg;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.direct && !s.en_pwm) |=> (coil_a.reg_en && coil_b.reg_en);
    endproperty
    a_both_reg: assert property (p_both_reg) else $error("bridge not regulated"); // R12
    property p_standstill_output_option;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.direct && s.standstill_current_scale == 5'h0 && s.fw == 2'h1 && !s.boost) |=> coil_standstill_output_option;
    endproperty
    a_standstill_output_option: assert property (p_standstill_output_option) else $error("no standstill_output_option"); // R9
    property p_no_sense;
        @(posedge ref_clk) disable iff (!rst_n)
        (s.en_pwm && !s.autoscale) |=> (s.scale == 8'hff && !coil_a.reg_en && !coil_b.reg_en);
    endproperty
    a_no_sense: assert property (p_no_sense) else $error("sensing used"); // R8
endmodule
`default_nettype wire

// file: sim/coil_load_model.sv
// load model: dc motors or solenoids hanging on the two coil bridges
// assumes the block's registered coil outputs and its one clock
`timescale 1ns/1ns
`default_nettype none
module coil_load_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [1:0] stall,
    input wire coil_drive_pkg::coil_drive_s coil_a,
    input wire coil_drive_pkg::coil_drive_s coil_b,
    output logic [1:0] over_limit
);
    ////////////////////////////////////////////////////////////////////////
    // a stalled load only draws excess current while its bridge is driven;
    // one cycle of lag stands in for the coil inductance
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            over_limit <= 2'h0;
        else
            over_limit <= stall & {coil_b.duty != 9'h000, coil_a.duty != 9'h000};
    end
endmodule
`default_nettype wire

// file: sim/tb_direct_coil_drive.sv
// testbench: register access over both links, coil setpoints, boost, standstill_output_option
// assumes the coil load model on the bridges and a 125 MHz reference clock
`timescale 1ns/1ns
`default_nettype none
module tb_direct_coil_drive;
    logic ref_clk, rst_n, step_in, inc_pin, spi_csn, spi_sclk, spi_sdi, uart_in;
    logic spi_sdo, uart_out, uart_oe, coil_standstill_output_option, driver_enable;
    logic [1:0] over, stall;
    logic [31:0] rdv;
    logic [7:0] stv;
    logic [39:0] rx;
    logic [63:0] fr;
    coil_drive_pkg::coil_drive_s coil_a, coil_b;
    int err_total = 0;
    int n_checks = 0;

    direct_coil_drive #(.PD_TICK(16)) dut (.ref_clk(ref_clk), .rst_n(rst_n),
        .step_in(step_in), .coil_over_limit(over), .address_increment_input(inc_pin),
        .spi_csn(spi_csn), .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
        .uart_in(uart_in), .uart_out(uart_out), .uart_oe(uart_oe), .coil_a(coil_a),
        .coil_b(coil_b), .coil_standstill_output_option(coil_standstill_output_option), .driver_enable(driver_enable));
    coil_load_model load (.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall),
        .coil_a(coil_a), .coil_b(coil_b), .over_limit(over));

    ////////////////////////////////////////////////////////////////////////
    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge ref_clk);
            #1;
        end
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // mode 3: data set on the falling edge, captured on the rising edge
    task automatic spi(input logic [39:0] tx, input int n);
        rx = 40'h0;
        spi_csn = 1'b0;
        tick(3);
        for (int i = 0; i < n; i++)
        begin
            spi_sclk = 1'b0;
            spi_sdi = tx[39-i];
            tick(3);
            rx = {rx[38:0], spi_sdo};
            spi_sclk = 1'b1;
            tick(3);
        end
        spi_csn = 1'b1;
        tick(6);
    endtask

    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        spi({1'b1, a, d}, 40);
    endtask

    // first datagram names the register, the second one carries it back
    task automatic rd(input logic [6:0] a);
        spi({1'b0, a, 32'h0}, 40);
        spi({1'b0, a, 32'h0}, 40);
        rdv = rx[31:0];
        stv = rx[39:32];
    endtask

    function automatic logic [7:0] crc8(input logic [63:0] f, input int n);
        logic [7:0] c;
        logic [7:0] b;
        c = 8'h00;
        for (int k = 0; k < n; k++)
        begin
            b = f[63-8*k -: 8];
            for (int j = 0; j < 8; j++)
                c = (c[7] ^ b[j]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    task automatic uart_frame(input logic [63:0] f);
        logic [9:0] bits;
        for (int k = 0; k < 8; k++)
        begin
            bits = {1'b1, f[63-8*k -: 8], 1'b0};
            for (int i = 0; i < 10; i++)
            begin
                uart_in = bits[i];
                tick(coil_drive_pkg::BIT_CYC);
            end
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // the single-wire frame alone takes about 87k cycles
    initial
    begin
        repeat (120000) @(posedge ref_clk);
        err_total++;
        give_verdict();
    end

    initial
    begin
        {step_in, spi_sdi, stall} = '0;
        {spi_csn, spi_sclk, uart_in, inc_pin} = 4'hf;
        rst_n = 1'b0;
        tick(3);
        rst_n = 1'b1;
        tick(1);
        check("coil_a", 32'(coil_a), 32'h0);
        check("idle", 32'({uart_out, uart_oe, driver_enable, coil_standstill_output_option}), 32'h8);
        $display("test reset done");

        wr(coil_drive_pkg::A_TARGET, 32'h0064_0138);
        wr(coil_drive_pkg::A_CURRENT, 32'h0000_001f);
        // step with direct off must not start a boost
        step_in = 1'b1;
        tick(4);
        step_in = 1'b0;
        check("coil_a", 32'(coil_a), 32'h0);
        wr(coil_drive_pkg::A_GLOBAL_CONFIGURATION, 32'h0001_0000);
        check("coil_a", 32'(coil_a), 32'({9'h138, 8'hc8, 1'b1}));
        check("coil_b", 32'(coil_b), 32'({9'h064, 8'h64, 1'b1}));
        wr(coil_drive_pkg::A_CURRENT, 32'h0000_000f);
        check("limit_a", 32'(coil_a.limit), 32'h64);
        rd(coil_drive_pkg::A_TARGET);
        check("target", rdv, 32'h0064_0138);
        check("status", 32'(stv), 32'h1);
        spi({1'b1, coil_drive_pkg::A_TARGET, 32'h0}, 39);
        rd(coil_drive_pkg::A_TARGET);
        check("target", rdv, 32'h0064_0138);
        rd(7'h7f);
        check("unmapped", rdv, 32'h0);
        step_in = 1'b1;
        tick(4);
        step_in = 1'b0;
        rd(coil_drive_pkg::A_POSITION);
        check("position", rdv, 32'h0);
        $display("test direct hysteresis done");

        wr(coil_drive_pkg::A_CURRENT, 32'h0000_1404);
        wr(coil_drive_pkg::A_POWERDOWN, 32'h0000_0002);
        wr(coil_drive_pkg::A_TARGET, 32'h019c_0064);
        tick(150);
        check("limit_a", 32'(coil_a.limit), 32'h0f);
        step_in = 1'b1;
        tick(4);
        step_in = 1'b0;
        tick(4);
        check("limit_a", 32'(coil_a.limit), 32'h41);
        check("limit_b", 32'(coil_b.limit), 32'h41);
        tick(150);
        check("limit_b", 32'(coil_b.limit), 32'h0f);
        $display("test boost done");

        wr(coil_drive_pkg::A_CURRENT, 32'h0);
        wr(coil_drive_pkg::A_PWMCONF, 32'h0010_0000);
        check("standstill_output_option", 32'(coil_standstill_output_option), 32'h1);
        wr(coil_drive_pkg::A_CHOPPER, 32'h5);
        check("enable", 32'(driver_enable), 32'h1);
        wr(coil_drive_pkg::A_CHOPPER, 32'h0);
        check("enable", 32'(driver_enable), 32'h0);
        $display("test standstill_output_option done");

        fr = {8'h05, 8'h01, 8'had, 32'h0012_0034, 8'h00};
        fr[7:0] = crc8(fr, 7);
        uart_frame(fr);
        tick(20);
        check("uart_oe", 32'(uart_oe), 32'h0);
        rd(coil_drive_pkg::A_TARGET);
        check("target", rdv, 32'h0012_0034);
        $display("test single wire done");

        wr(coil_drive_pkg::A_CURRENT, 32'h0000_001f);
        wr(coil_drive_pkg::A_CHOPPER, 32'h5);
        wr(coil_drive_pkg::A_PWMCONF, 32'h0000_04ff);
        wr(coil_drive_pkg::A_GLOBAL_CONFIGURATION, 32'h0001_0004);
        wr(coil_drive_pkg::A_TARGET, 32'h0032_0100);
        check("duty_a", 32'(coil_a.duty), 32'h101);
        check("duty_b", 32'(coil_b.duty), 32'h032);
        stall = 2'b01;
        tick(20);
        check("duty_b", 32'(coil_b.duty), 32'h032);
        stall = 2'b00;
        wr(coil_drive_pkg::A_PWMCONF, 32'h0004_04ff);
        check("coil_a", 32'(coil_a), 32'({9'h101, 8'hff, 1'b1}));
        check("coil_b", 32'(coil_b), 32'({9'h032, 8'h32, 1'b0}));
        stall = 2'b01;
        tick(20);
        check("duty_b_drop", 32'(coil_b.duty < 9'h032), 32'h1);
        check("duty_a_drop", 32'(coil_a.duty > 9'h101), 32'h1);
        $display("test voltage duty done");
        give_verdict();
    end
endmodule
`default_nettype wire
